// >>> rtl/mpw_pkg.sv
// Shared constants for the interleaved multiphase pulse timing block
package mpw_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  // Default switching cycle length in clk_sys cycles (one period of the cycle clock)
  localparam int unsigned CYCLE_LEN_DEF = 500;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned CH_N = 4;
  // Interleave divisors per timing mode
  localparam logic [2:0] DIV_2PH = 3'h2;
  localparam logic [2:0] DIV_3PH = 3'h3;
  localparam logic [2:0] DIV_4PH = 3'h4;
  // Forced off time is a quarter cycle: shift by two
  localparam int unsigned OFF_SHIFT = 2;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  typedef enum logic [2:0] {
    MPW_MODE_2 = 3'b001,
    MPW_MODE_3 = 3'b010,
    MPW_MODE_4 = 3'b100
  } mpw_mode_t;

  typedef enum logic [2:0] {
    MPW_CH_IDLE = 3'b001,
    MPW_CH_OFF = 3'b010,
    MPW_CH_ARMED = 3'b100
  } mpw_ch_state_t;
endpackage : mpw_pkg

// >>> rtl/mpw_sync_gate.sv
// Enable qualification: combines both enable conditions into one registered level
`timescale 1ns/100ps
`default_nettype none
module mpw_sync_gate (
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic en_above_thresh, // Enable input above rising threshold
  input wire logic fs_below_thresh, // Frequency-set pin pulled below disable level
  output logic run_reg // Block may sequence
);
  // Low frequency-set level overrides enable
  wire run_next = en_above_thresh & ~fs_below_thresh;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      run_reg <= 1'b0;
    end else begin
      run_reg <= run_next;
    end
  end
endmodule : mpw_sync_gate
`default_nettype wire

// >>> rtl/mpw_window_mon.sv
// Output window monitor: drives the power-good flag from two comparator levels
`timescale 1ns/100ps
`default_nettype none
module mpw_window_mon (
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic volt_below_90pct, // Sensed output below 90 percent of reference
  input wire logic volt_above_2v1, // Sensed output above 2.1 V
  input wire logic run, // Block enabled
  output logic in_window_reg // Power-good level
);
  // Good only while running and inside the window
  wire in_window_next = run & ~volt_below_90pct & ~volt_above_2v1;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      in_window_reg <= 1'b0;
    end else begin
      in_window_reg <= in_window_next;
    end
  end
endmodule : mpw_window_mon
`default_nettype wire

// >>> rtl/mpw_timing.sv
// Interleaved multiphase pulse timing: phase sequencer, forced off time, crossing set
// Notes on behaviour
// - No optional output strapped high: run four-phase timing.
// - Output three strapped high: two-phase timing, channels one and two only.
// - Output four strapped high, output three not: three-phase timing, channels one to three.
// - Cycle starts with channel-one termination; cycle spans successive ones.
// - Two-phase: channel two terminates half a cycle after channel one.
// - Three-phase: terminations spaced one third of a cycle apart.
// - Four-phase: terminations spaced a quarter cycle, in channel order.
// - After termination an output stays low at least a quarter cycle.
// - After forced off the channel arms and rises at first crossing.
// - A high output stays high until its next termination command.
// - Power-good low when output under 90 percent of reference or over 2.1 V.
// - Frequency-set pin under 1 V disables the block regardless of enable.
`timescale 1ns/100ps
`default_nettype none
module mpw_timing #(
  parameter logic [15:0] CYCLE_LEN = 16'(mpw_pkg::CYCLE_LEN_DEF) // Clocks per switching cycle
) (
  input wire logic clk_sys, // System clock, 125 MHz
  input wire logic resetn, // Synchronous reset, active low
  input wire logic en_above_thresh, // Enable comparator above 1.23 V
  input wire logic freq_set_pin_low, // Frequency-set pin below 1 V
  input wire logic out3_strapped, // Output three strapped to supply
  input wire logic out4_strapped, // Output four strapped to supply
  input wire logic [3:0] ramp_cross, // Sawtooth crossed adjusted error level, per channel
  input wire logic volt_below_90pct, // Sensed output voltage under 90 percent
  input wire logic volt_above_2v1, // Sensed output voltage over 2.1 V
  output logic phase_drive_out_1, // Channel one drive
  output logic phase_drive_out_2, // Channel two drive
  output logic phase_drive_out_3, // Channel three drive
  output logic phase_drive_out_4, // Channel four drive
  output logic phase_drive_oe_3, // Output three driven (released when strapped)
  output logic phase_drive_oe_4, // Output four driven (released when strapped)
  output logic output_in_window_flag, // Power-good level
  output logic [2:0] phase_mode // Active timing mode, one-hot
);
  localparam int unsigned N = mpw_pkg::CH_N;

  // Termination offset of a channel within the cycle
  function automatic logic [15:0] term_offset(input logic [15:0] len, input logic [2:0] div,
                                              input int unsigned idx);
    logic [31:0] prod;
    prod = 32'(len) * 32'(idx);
    term_offset = 16'(prod / 32'(div));
  endfunction : term_offset

  logic run;
  logic strap_seen_reg;
  logic [2:0] mode_reg;
  logic [2:0] mode_next;
  logic [15:0] cyc_cnt_reg;
  logic [15:0] cyc_cnt_next;
  logic run_d_reg;
  logic [N-1:0] drive_reg;
  logic [N-1:0] oe_reg;
  logic [N-1:0] active_mask;
  logic [N-1:0] term_hit;
  mpw_pkg::mpw_ch_state_t st_reg [N];
  logic [15:0] off_cnt_reg [N];
  logic in_window;

  mpw_sync_gate u_gate (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .en_above_thresh(en_above_thresh),
    .fs_below_thresh(freq_set_pin_low),
    .run_reg(run)
  );

  mpw_window_mon u_mon (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .volt_below_90pct(volt_below_90pct),
    .volt_above_2v1(volt_above_2v1),
    .run(run),
    .in_window_reg(in_window)
  );

  // Mode decode from the straps; output three strap wins as it disables two channels
  assign mode_next = out3_strapped ? mpw_pkg::MPW_MODE_2 :
                     out4_strapped ? mpw_pkg::MPW_MODE_3 :
                                     mpw_pkg::MPW_MODE_4;
  wire [2:0] div_sel = (mode_reg == mpw_pkg::MPW_MODE_2) ? mpw_pkg::DIV_2PH :
                       (mode_reg == mpw_pkg::MPW_MODE_3) ? mpw_pkg::DIV_3PH : mpw_pkg::DIV_4PH;
  assign active_mask = (mode_reg == mpw_pkg::MPW_MODE_2) ? 4'h3 :
                       (mode_reg == mpw_pkg::MPW_MODE_3) ? 4'h7 : 4'hf;
  wire [15:0] off_len = CYCLE_LEN >> mpw_pkg::OFF_SHIFT;
  wire run_rise = run & ~run_d_reg;

  // Straps are caught once after reset release; live changes would tear the interleave
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      strap_seen_reg <= 1'b0;
      mode_reg <= mpw_pkg::MPW_MODE_4;
    end else if (!strap_seen_reg) begin
      strap_seen_reg <= 1'b1;
      mode_reg <= mode_next;
    end
  end

  // Cycle counter: zero is the channel-one termination point
  assign cyc_cnt_next = (!run || run_rise) ? mpw_pkg::CNT_ZERO :
                        (cyc_cnt_reg == CYCLE_LEN - mpw_pkg::CNT_ONE) ? mpw_pkg::CNT_ZERO :
                        cyc_cnt_reg + mpw_pkg::CNT_ONE;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cyc_cnt_reg <= mpw_pkg::CNT_ZERO;
      run_d_reg <= 1'b0;
    end else begin
      cyc_cnt_reg <= cyc_cnt_next;
      run_d_reg <= run;
    end
  end

  // Per-channel termination commands at evenly spaced offsets
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      assign term_hit[g] = run && active_mask[g] && strap_seen_reg &&
                           (cyc_cnt_next == term_offset(CYCLE_LEN, div_sel, g));
      wire off_done = (off_cnt_reg[g] == mpw_pkg::CNT_ZERO);

      // Channel state: forced off, then armed, then high until next termination
      always_ff @(posedge clk_sys) begin
        if (!resetn || !run) begin
          st_reg[g] <= mpw_pkg::MPW_CH_IDLE;
          off_cnt_reg[g] <= mpw_pkg::CNT_ZERO;
          drive_reg[g] <= 1'b0;
        end else if (term_hit[g]) begin
          st_reg[g] <= mpw_pkg::MPW_CH_OFF;
          off_cnt_reg[g] <= off_len - mpw_pkg::CNT_ONE;
          drive_reg[g] <= 1'b0;
        end else begin
          case (st_reg[g])
            mpw_pkg::MPW_CH_IDLE: begin
              drive_reg[g] <= 1'b0;
            end
            mpw_pkg::MPW_CH_OFF: begin
              drive_reg[g] <= 1'b0;
              if (off_done) begin
                st_reg[g] <= mpw_pkg::MPW_CH_ARMED;
              end else begin
                off_cnt_reg[g] <= off_cnt_reg[g] - mpw_pkg::CNT_ONE;
              end
            end
            mpw_pkg::MPW_CH_ARMED: begin
              // Set once on crossing and held; no crossing means zero duty
              if (ramp_cross[g]) begin
                drive_reg[g] <= 1'b1;
              end
            end
            default: begin
              st_reg[g] <= mpw_pkg::MPW_CH_IDLE;
              drive_reg[g] <= 1'b0;
            end
          endcase
        end
      end

      // Strapped outputs are released so the supply strap is not fought
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          oe_reg[g] <= 1'b0;
        end else begin
          oe_reg[g] <= strap_seen_reg & active_mask[g];
        end
      end

      // Low-run length, saturating so a long zero-duty stretch cannot wrap into a false short one
      logic [15:0] low_run_reg;
      always_ff @(posedge clk_sys) begin
        if (!resetn || drive_reg[g]) begin
          low_run_reg <= mpw_pkg::CNT_ZERO;
        end else if (low_run_reg != ~mpw_pkg::CNT_ZERO) begin
          low_run_reg <= low_run_reg + mpw_pkg::CNT_ONE;
        end
      end

      // A rise only after a full forced off stretch, whatever the cycle length
      off_time_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(drive_reg[g]) |-> (low_run_reg >= off_len))
        else $error("channel rose inside forced off time");
      // Forced off ends in the armed state
      arm_after_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (run && !term_hit[g] && st_reg[g] == mpw_pkg::MPW_CH_OFF && off_cnt_reg[g] == mpw_pkg::CNT_ZERO)
          |=> (st_reg[g] == mpw_pkg::MPW_CH_ARMED))
        else $error("channel not armed after forced off");
      // A crossing while armed sets the output on the next edge
      arm_rise_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (run && !term_hit[g] && st_reg[g] == mpw_pkg::MPW_CH_ARMED && ramp_cross[g]) |=> drive_reg[g])
        else $error("armed channel missed its crossing");
      // No crossing, no pulse
      zero_duty_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!drive_reg[g] && !ramp_cross[g]) |=> !drive_reg[g])
        else $error("channel rose with no crossing");
      // Termination always pulls the output low on the next edge
      term_low_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        term_hit[g] |=> !drive_reg[g])
        else $error("channel high after its termination");
      // Channels outside the timing mode never drive
      inactive_low_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !active_mask[g] |-> !drive_reg[g])
        else $error("inactive channel driven");
    end
  endgenerate

  // Outputs straight from flops
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      output_in_window_flag <= 1'b0;
      phase_mode <= mpw_pkg::MPW_MODE_4;
    end else begin
      output_in_window_flag <= in_window;
      phase_mode <= mode_reg;
    end
  end
  assign phase_drive_out_1 = drive_reg[0];
  assign phase_drive_out_2 = drive_reg[1];
  assign phase_drive_out_3 = drive_reg[2];
  assign phase_drive_out_4 = drive_reg[3];
  assign phase_drive_oe_3 = oe_reg[2];
  assign phase_drive_oe_4 = oe_reg[3];

  // Helper: clocks since last channel-one termination
  logic [15:0] since_t1_reg;
  always_ff @(posedge clk_sys) begin
    if (!resetn || term_hit[0]) begin
      since_t1_reg <= mpw_pkg::CNT_ZERO;
    end else begin
      since_t1_reg <= since_t1_reg + mpw_pkg::CNT_ONE;
    end
  end


  // Checks on the sequencer, the straps and the flag
  // Channel two holds high between its terminations
  hold_high_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (drive_reg[1] && run && !term_hit[1]) |=> drive_reg[1])
    else $error("channel two dropped without termination");
  // Disable clears every phase drive output on the next edge
  disable_low_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !run |=> (drive_reg == 4'h0))
    else $error("output high while disabled");
  // Low frequency-set level overrides enable one edge later
  fs_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    freq_set_pin_low |-> ##1 !run)
    else $error("frequency-set low did not disable");
  // Window faults reach the flag through two register stages
  output_in_window_flag_low_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (volt_above_2v1 || volt_below_90pct) |-> ##2 !output_in_window_flag)
    else $error("power-good high outside window");
  // A disabled block never reports good
  pg_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !run |-> ##2 !output_in_window_flag)
    else $error("power-good high while disabled");
  // Straps land in the mode register on the capture edge
  mode_pick_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(strap_seen_reg) |-> (mode_reg == $past(mode_next)))
    else $error("timing mode does not follow the straps");
  // Two-phase keeps outputs three and four low
  two_phase_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (mode_reg == mpw_pkg::MPW_MODE_2) |-> (drive_reg[3:2] == 2'b00))
    else $error("channel three or four driven in two-phase mode");
  // Three-phase keeps output four low
  three_phase_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (mode_reg == mpw_pkg::MPW_MODE_3) |-> !drive_reg[3])
    else $error("channel four driven in three-phase mode");
  // Output four is released whenever fewer than four phases run
  strap_rel_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (strap_seen_reg && mode_reg != mpw_pkg::MPW_MODE_4) |=> !oe_reg[3])
    else $error("strapped output four still driven");
  // Channel two termination point per mode; a fall caused by disable is left out
  half_space_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ((mode_reg == mpw_pkg::MPW_MODE_2) && $fell(drive_reg[1]) && $past(run))
      |-> (cyc_cnt_reg == CYCLE_LEN / 16'(mpw_pkg::DIV_2PH)))
    else $error("two-phase channel two not half a cycle late");
  third_space_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ((mode_reg == mpw_pkg::MPW_MODE_3) && $fell(drive_reg[1]) && $past(run))
      |-> (cyc_cnt_reg == CYCLE_LEN / 16'(mpw_pkg::DIV_3PH)))
    else $error("three-phase channel two not a third of a cycle late");
  quarter_space_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ((mode_reg == mpw_pkg::MPW_MODE_4) && $fell(drive_reg[1]) && $past(run))
      |-> (cyc_cnt_reg == CYCLE_LEN / 16'(mpw_pkg::DIV_4PH)))
    else $error("four-phase channel two not a quarter cycle late");
  // Each enable restarts the sequence at channel one
  restart_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    run_rise |-> term_hit[0])
    else $error("re-enable did not start with channel one");
  // Channel-one terminations one full cycle apart
  cycle_len_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (term_hit[0] && $past(run) && run && !$past(run_rise)) |-> (since_t1_reg == CYCLE_LEN - mpw_pkg::CNT_ONE))
    else $error("channel one termination period wrong");
  // Channel one rises only on a crossing
  rise_cross_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(drive_reg[0]) |-> $past(ramp_cross[0]))
    else $error("channel one rose without crossing");
endmodule : mpw_timing
`default_nettype wire

// >>> bench/mpw_drv_model.sv
// Behavioural gate driver for one phase output
`timescale 1ns/100ps
`default_nettype none
module mpw_drv_model (
  input wire logic drive_in, // Phase drive level
  output logic upper_on, // Upper switch on
  output logic lower_on // Synchronous switch on
);
  // Dead time left out: both switches follow the drive at once
  assign upper_on = drive_in;
  assign lower_on = !drive_in;
endmodule : mpw_drv_model
`default_nettype wire

// >>> bench/test_multiphase_interleaved_pwm_timing.sv
// Self-checking bench for the interleaved pulse timing block
`timescale 1ns/100ps
`default_nettype none
module test_multiphase_interleaved_pwm_timing;
  localparam int L = 24; // Short cycle keeps runs brief
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic en_above_thresh = 1'b0;
  logic freq_set_pin_low = 1'b0;
  logic out3_strapped = 1'b0;
  logic out4_strapped = 1'b0;
  logic [3:0] ramp_cross = 4'h0;
  logic volt_below_90pct = 1'b0;
  logic volt_above_2v1 = 1'b0;
  wire logic [3:0] drv;
  wire logic [3:0] up_on;
  wire logic [3:0] lo_on;
  wire logic oe3, oe4, pg;
  wire logic [2:0] phase_mode;
  logic [3:0] drv_q = 4'h0;
  logic [3:0] rq1 = 4'h0;
  logic [3:0] rq2 = 4'h0;
  int cyc = 0;
  int prev_t0 = 0;
  int fall_t [4];
  int low_cnt [4];
  int rises [4];
  int num_errors = 0;
  int compares = 0;
  int dv;
  always #4 clk_sys = ~clk_sys;
  mpw_timing #(.CYCLE_LEN(16'(L))) uut (.clk_sys(clk_sys), .resetn(resetn), .en_above_thresh(en_above_thresh),
    .freq_set_pin_low(freq_set_pin_low), .out3_strapped(out3_strapped), .out4_strapped(out4_strapped),
    .ramp_cross(ramp_cross), .volt_below_90pct(volt_below_90pct), .volt_above_2v1(volt_above_2v1),
    .phase_drive_out_1(drv[0]), .phase_drive_out_2(drv[1]), .phase_drive_out_3(drv[2]),
    .phase_drive_out_4(drv[3]), .phase_drive_oe_3(oe3), .phase_drive_oe_4(oe4),
    .output_in_window_flag(pg), .phase_mode(phase_mode));
  // One driver model per phase
  for (genvar g = 0; g < 4; g++) begin : g_drv
    mpw_drv_model u_drv (.drive_in(drv[g]), .upper_on(up_on[g]), .lower_on(lo_on[g]));
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  // Edge history; a rise needs a recent crossing and a full off time
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    drv_q <= drv;
    rq1 <= ramp_cross;
    rq2 <= rq1;
    for (int k = 0; k < 4; k++) begin
      low_cnt[k] <= drv[k] ? 0 : low_cnt[k] + 1;
      if (drv_q[k] && !drv[k]) begin
        fall_t[k] <= cyc;
        chk("lower_on", 16'h0001, 16'(lo_on[k]));
        if (k == 0) prev_t0 <= fall_t[0];
      end
      if (!drv_q[k] && drv[k]) begin
        rises[k] <= rises[k] + 1;
        chk("upper_on", 16'h0001, 16'(up_on[k]));
        chk("off_time", 16'h0001, 16'(low_cnt[k] >= L / 4));
        chk("rise_cause", 16'h0001, 16'(rq1[k] | rq2[k]));
      end
    end
  end
  function automatic int exp_div(input logic s3, input logic s4);
    return s3 ? 2 : (s4 ? 3 : 4);
  endfunction : exp_div
  task automatic restart(input logic s3, input logic s4);
    resetn <= 1'b0;
    en_above_thresh <= 1'b0;
    out3_strapped <= s3;
    out4_strapped <= s4;
    repeat (16) @(posedge clk_sys);
    chk("reset_drive", 16'h0000, 16'(drv));
    chk("reset_mode", 16'h0004, 16'(phase_mode));
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask : restart
  task automatic check_spacing(input int div);
    chk("period", 16'(L), 16'(fall_t[0] - prev_t0));
    for (int k = 1; k < 4; k++) begin
      if (k < div) chk("spacing", 16'(L * k / div), 16'((fall_t[k] - fall_t[0] + L) % L));
      else chk("idle_ch", 16'h0000, 16'(rises[k]));
    end
  endtask : check_spacing
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  initial begin
    dv = $urandom(55);
    // Every strap pair, including both strapped
    for (int m = 0; m < 4; m++) begin
      restart(m[0], m[1]);
      dv = exp_div(m[0], m[1]);
      chk("mode", 16'(1 << (dv - 2)), 16'(phase_mode));
      en_above_thresh <= 1'b1;
      ramp_cross <= 4'hf;
      rises = '{default: 0};
      repeat (5 * L) @(posedge clk_sys);
      check_spacing(dv);
      chk("oe", 16'({dv == 4, dv >= 3}), 16'({oe4, oe3}));
      $display("test mode %0d done", m);
    end
    // No crossing at all, then random crossings
    restart(1'b0, 1'b0);
    en_above_thresh <= 1'b1;
    ramp_cross <= 4'h0;
    rises = '{default: 0};
    repeat (3 * L) @(posedge clk_sys);
    chk("zero_duty", 16'h0000, 16'(rises.sum()));
    repeat (20 * L) begin
      ramp_cross <= 4'($urandom);
      @(posedge clk_sys);
    end
    check_spacing(4);
    $display("test random crossing done");
    // Enable low, then frequency pin low with enable high
    for (int c = 0; c < 2; c++) begin
      en_above_thresh <= c[0];
      freq_set_pin_low <= c[0];
      ramp_cross <= 4'hf;
      repeat (4) @(posedge clk_sys);
      rises = '{default: 0};
      repeat (2 * L) @(posedge clk_sys);
      chk("off_drive", 16'h0000, 16'({drv, 12'h000} | 16'(rises.sum())));
      chk("off_pg", 16'h0000, 16'(pg));
      en_above_thresh <= 1'b1;
      freq_set_pin_low <= 1'b0;
      repeat (3 * L) @(posedge clk_sys);
      check_spacing(4);
    end
    $display("test disable done");
    // Window comparator combinations
    for (int v = 0; v < 4; v++) begin
      volt_below_90pct <= v[0];
      volt_above_2v1 <= v[1];
      repeat (4) @(posedge clk_sys);
      chk("pg", 16'(v == 0), 16'(pg));
    end
    $display("test power good done");
    report_and_stop();
  end
endmodule : test_multiphase_interleaved_pwm_timing
`default_nettype wire
